/* File: pin_func_pkg.sv */
// package: register map, field positions and carrier types of the pin function block
package pin_func_pkg;
   // ************************************************************
   // register word indices, byte addresses, reset value and unlock key
   // ************************************************************
   localparam logic [7:0] comparator_status_idx = 8'h23;
   localparam logic [7:0] pin_cfg_idx = 8'h24;
   localparam logic [7:0] cmp_clear_addr = 8'hA0;
   localparam logic [7:0] map_unlock_addr = 8'hA4;
   localparam logic [7:0] action_addr = 8'hA8;
   localparam logic [9:0] comparator_status_addr = {comparator_status_idx, 2'b00};
   localparam logic [9:0] pin_cfg_addr = {pin_cfg_idx, 2'b00};
   localparam logic [15:0] pin_cfg_reset = 16'h0000;
   localparam logic [15:0] map_unlock_key = 16'hA5C3;
   // ************************************************************
   // field positions and glitch filter length
   // ************************************************************
   localparam int glitch_bit = 15;
   localparam int sleep_en_bit = 14;
   localparam int out_en_bit = 13;
   localparam int out_sel_lo = 9;
   localparam int ch_sel_lo = 5;
   localparam int in_func_lo = 1;
   localparam int in_en_bit = 0;
   localparam int protect_bit = 8;
   localparam int glitch_cycles = 4;
   // ************************************************************
   // input function codes
   // ************************************************************
   typedef enum logic [3:0] {
      fn_sleep = 4'h0, fn_fault = 4'h2, fn_current_output = 4'h3, fn_voltage_output = 4'h4,
      fn_protect = 4'h5, fn_clear = 4'h7, fn_load = 4'h8, fn_wave = 4'h9,
      fn_margin = 4'hA, fn_reset = 4'hB, fn_nvm = 4'hC, fn_lock = 4'hD
   } in_func_t;
   // per-channel command strobes toward the analog channels
   typedef struct packed {
      logic [3:0] current_output_off;
      logic [3:0] current_output_on;
      logic [3:0] voltage_output_off;
      logic [3:0] voltage_output_on;
      logic [3:0] load;
      logic [3:0] wave_start;
      logic [3:0] wave_stop;
      logic [3:0] margin_lo;
      logic [3:0] margin_hi;
   } chan_cmd_t;
   // global actions and levels
   typedef struct packed {
      logic sleep;
      logic fault_snapshot;
      logic protect_start;
      logic clear;
      logic dev_reset;
      logic nvm_write_ok;
      logic map_locked;
   } glob_cmd_t;
endpackage

/* File: pin_func.sv */
// pin function logic with comparator status word and wishbone register slave
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
// Functional notes
// RULE_01: protect flag set while running, cleared on read
// RULE_02: window results latched or live per setting
// RULE_03: comparator outputs synchronised into status bits
// RULE_04: bit fifteen inserts pin glitch filter
// RULE_05: bit fourteen enables deep sleep input
// RULE_06: bit thirteen enables pin output mode
// RULE_07: output select picks busy or window bit
// RULE_08: channel select gates per-channel actions
// RULE_09: code 0000 falling sleeps, rising wakes
// RULE_10: code 0010 falling triggers fault snapshot
// RULE_11: code 0011 toggles current outputs power
// RULE_12: code 0100 toggles voltage outputs power
// RULE_13: code 0101 falling starts safe shutdown
// RULE_14: code 0111 clear held while pin low
// RULE_15: code 1000 falling loads selected synced channels
// RULE_16: code 1001 rising starts, falling stops waveform
// RULE_17: code 1010 falling margin low, rising high
// RULE_18: code 1011 falling resets until rising
// RULE_19: reset clears config unless stored nonvolatile
// RULE_20: code 1100 falling permits memory programming
// RULE_21: code 1101 rising locks register writes
// RULE_22: bit zero enables any pin input function
// RULE_23: flag clear write resets latched comparators
// RULE_24: pin synchronised before edge detection
module pin_func #(
   parameter int glitch_len = pin_func_pkg::glitch_cycles
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   input wire logic [3:0] compare_raw_i,
   input wire logic [3:0] window_raw_i,
   input wire logic window_latch_en_i,
   input wire logic [3:0] sync_update_i,
   input wire logic [3:0] chan_busy_i,
   input wire logic memory_busy_i,
   input wire logic protect_active_i,
   input wire logic nvm_cfg_valid_i,
   input wire logic [15:0] nvm_cfg_i,
   output pin_func_pkg::chan_cmd_t chan_cmd_o,
   output pin_func_pkg::glob_cmd_t glob_cmd_o
);
   // ************************************************************
   // state
   // ************************************************************
   logic [15:0] cfg_reg, cfg_next;
   logic [2:0] pin_sync_reg, pin_sync_next;
   logic [2:0] cmp_sync_reg [4];
   logic [2:0] win_sync_reg [4];
   logic pin_level_reg, pin_level_next;
   logic [7:0] filt_cnt_reg, filt_cnt_next;
   logic [3:0] win_latch_reg, win_latch_next;
   logic [3:0] cmp_stat_reg, cmp_stat_next;
   logic protect_reg, protect_next;
   logic sleep_reg, sleep_next;
   logic nvm_ok_reg, nvm_ok_next;
   logic lock_reg, lock_next;
   logic reset_hold_reg, reset_hold_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic pin_out_reg, pin_out_next;
   logic pin_oe_reg, pin_oe_next;
   logic lock_next_override;
   logic hold_keep;
   pin_func_pkg::chan_cmd_t chan_reg, chan_next;
   pin_func_pkg::glob_cmd_t glob_reg, glob_next;

   logic pin_stable, pin_agree, fall, rise, in_on;
   logic req, wr, rd;
   logic [3:0] ch_sel, live_win;
   pin_func_pkg::in_func_t in_func;

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0] = d[7:0];
      if (sel[1]) r[15:8] = d[15:8];
      return r;
   endfunction

   // ************************************************************
   // synchronisers for pin and comparator inputs
   // ************************************************************
   // comparator bits pass three flops, accepted once stages two and three agree
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (rst_i) begin
            cmp_sync_reg[i] <= 3'h0;
            win_sync_reg[i] <= 3'h0;
         end else begin
            cmp_sync_reg[i] <= {cmp_sync_reg[i][1:0], compare_raw_i[i]}; // RULE_03
            win_sync_reg[i] <= {win_sync_reg[i][1:0], window_raw_i[i]};
         end
      end
   end

   // live window value only where second and third stages match
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         live_win[i] = (win_sync_reg[i][2] == win_sync_reg[i][1]) ? win_sync_reg[i][2] : win_latch_reg[i];
      end
   end

   assign pin_sync_next = {pin_sync_reg[1:0], pin_i}; // RULE_24
   assign pin_agree = (pin_sync_reg[2] == pin_sync_reg[1]);
   assign in_func = pin_func_pkg::in_func_t'(cfg_reg[pin_func_pkg::in_func_lo +: 4]);
   assign ch_sel = cfg_reg[pin_func_pkg::ch_sel_lo +: 4];
   assign in_on = cfg_reg[pin_func_pkg::in_en_bit]; // RULE_22

   // ************************************************************
   // glitch filter and edge detection
   // ************************************************************
   // filtered path requires the new level to persist glitch_len cycles
   always_comb begin
      pin_level_next = pin_level_reg;
      filt_cnt_next = 8'h00;
      pin_stable = 1'b0;
      if (pin_agree && pin_sync_reg[2] != pin_level_reg) begin
         if (cfg_reg[pin_func_pkg::glitch_bit]) begin // RULE_04
            filt_cnt_next = filt_cnt_reg + 8'h01;
            if (filt_cnt_reg >= 8'(glitch_len - 1)) begin
               pin_stable = 1'b1;
               filt_cnt_next = 8'h00;
            end
         end else begin
            pin_stable = 1'b1;
         end
      end
      if (pin_stable) begin
         pin_level_next = pin_sync_reg[2];
      end
   end

   assign fall = pin_stable & pin_level_reg & in_on;
   assign rise = pin_stable & ~pin_level_reg & in_on;
   // pin-driven reset holds until the pin rises, whatever the config
   assign hold_keep = ~rst_i & ~(pin_stable & ~pin_level_reg); // RULE_18

   // ************************************************************
   // pin input function dispatch
   // ************************************************************
   always_comb begin
      chan_next = '0;
      glob_next = '0;
      sleep_next = sleep_reg;
      nvm_ok_next = nvm_ok_reg;
      lock_next = lock_reg;
      reset_hold_next = reset_hold_reg;
      case (in_func)
         pin_func_pkg::fn_sleep: begin
            if (cfg_reg[pin_func_pkg::sleep_en_bit]) begin // RULE_05
               if (fall) sleep_next = 1'b1; // RULE_09
               if (rise) sleep_next = 1'b0;
            end
         end
         pin_func_pkg::fn_fault: glob_next.fault_snapshot = fall; // RULE_10
         pin_func_pkg::fn_current_output: begin
            chan_next.current_output_off = {4{fall}} & ch_sel; // RULE_11
            chan_next.current_output_on = {4{rise}} & ch_sel; // RULE_08
         end
         pin_func_pkg::fn_voltage_output: begin
            chan_next.voltage_output_off = {4{fall}} & ch_sel; // RULE_12
            chan_next.voltage_output_on = {4{rise}} & ch_sel;
         end
         pin_func_pkg::fn_protect: glob_next.protect_start = fall; // RULE_13
         pin_func_pkg::fn_clear: glob_next.clear = in_on & ~pin_level_next; // RULE_14
         pin_func_pkg::fn_load: chan_next.load = {4{fall}} & ch_sel & sync_update_i; // RULE_15
         pin_func_pkg::fn_wave: begin
            chan_next.wave_start = {4{rise}} & ch_sel; // RULE_16
            chan_next.wave_stop = {4{fall}} & ch_sel;
         end
         pin_func_pkg::fn_margin: begin
            chan_next.margin_lo = {4{fall}} & ch_sel; // RULE_17
            chan_next.margin_hi = {4{rise}} & ch_sel;
         end
         pin_func_pkg::fn_reset: begin
            if (fall) reset_hold_next = 1'b1; // RULE_18
            if (rise) reset_hold_next = 1'b0;
         end
         pin_func_pkg::fn_nvm: begin
            if (fall) nvm_ok_next = 1'b1; // RULE_20
            if (rise) nvm_ok_next = 1'b0;
         end
         pin_func_pkg::fn_lock: begin
            if (fall) lock_next = 1'b0; // RULE_21
            if (rise) lock_next = 1'b1;
         end
         default: begin
         end
      endcase
      glob_next.sleep = sleep_next;
      glob_next.nvm_write_ok = nvm_ok_next;
      glob_next.map_locked = lock_next;
      glob_next.dev_reset = reset_hold_next;
   end

   // ************************************************************
   // wishbone slave and status
   // ************************************************************
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;

   // register writes, read mux, status flags
   always_comb begin
      cfg_next = cfg_reg;
      rdat_next = 32'h00000000;
      ack_next = req;
      lock_next_override = 1'b0;
      // a comparator bit moves only once stages two and three agree
      for (int i = 0; i < 4; i++) begin
         cmp_stat_next[i] = (cmp_sync_reg[i][2] == cmp_sync_reg[i][1]) ? cmp_sync_reg[i][2] : cmp_stat_reg[i];
      end
      win_latch_next = window_latch_en_i ? (win_latch_reg | live_win) : live_win; // RULE_02
      protect_next = protect_reg;
      if (wr && wb_adr_i == {pin_func_pkg::cmp_clear_addr, 2'b00} && wb_sel_i[0] && !lock_reg) begin
         // a new window hit in the clearing cycle wins over the clear
         win_latch_next = window_latch_en_i ? ((win_latch_reg & ~wb_dat_i[3:0]) | live_win) : live_win; // RULE_23
      end
      if (wr && wb_adr_i == {pin_func_pkg::map_unlock_addr, 2'b00}) begin
         if (lane_merge(16'h0000, wb_dat_i, wb_sel_i) == pin_func_pkg::map_unlock_key) begin
            lock_next_override = 1'b1;
         end
      end
      if (wr && wb_adr_i == pin_func_pkg::pin_cfg_addr && !lock_reg) begin
         cfg_next = lane_merge(cfg_reg, wb_dat_i, wb_sel_i);
      end
      if (rd && wb_adr_i == pin_func_pkg::comparator_status_addr) begin
         rdat_next = {23'h0, protect_reg, win_latch_reg, cmp_stat_reg};
         protect_next = 1'b0; // RULE_01
      end else if (rd && wb_adr_i == pin_func_pkg::pin_cfg_addr) begin
         rdat_next = {16'h0000, cfg_reg};
      end else if (rd && wb_adr_i == {pin_func_pkg::action_addr, 2'b00}) begin
         rdat_next = {28'h0000000, lock_reg, nvm_ok_reg, reset_hold_reg, sleep_reg};
      end
      if (protect_active_i) protect_next = 1'b1; // RULE_01
   end

   // ************************************************************
   // pin output
   // ************************************************************
   always_comb begin
      logic [3:0] sel;
      sel = cfg_reg[pin_func_pkg::out_sel_lo +: 4];
      pin_oe_next = cfg_reg[pin_func_pkg::out_en_bit]; // RULE_06
      pin_out_next = 1'b0;
      if (sel == 4'h1) pin_out_next = memory_busy_i; // RULE_07
      else if (sel[3:2] == 2'b01) pin_out_next = chan_busy_i[sel[1:0]];
      else if (sel[3:2] == 2'b10) pin_out_next = win_latch_reg[sel[1:0]];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || reset_hold_reg) begin
         cfg_reg <= nvm_cfg_valid_i ? nvm_cfg_i : pin_func_pkg::pin_cfg_reset; // RULE_19
         // the pin keeps being watched during a pin reset so its rise ends it
         pin_sync_reg <= rst_i ? 3'h7 : pin_sync_next;
         pin_level_reg <= rst_i ? 1'b1 : pin_level_next;
         filt_cnt_reg <= rst_i ? 8'h00 : filt_cnt_next;
         win_latch_reg <= 4'h0;
         cmp_stat_reg <= 4'h0;
         protect_reg <= 1'b0;
         sleep_reg <= 1'b0;
         nvm_ok_reg <= 1'b0;
         lock_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         chan_reg <= '0;
         glob_reg <= pin_func_pkg::glob_cmd_t'({4'h0, hold_keep, 2'b00});
         reset_hold_reg <= hold_keep; // RULE_18
      end else begin
         cfg_reg <= cfg_next;
         pin_sync_reg <= pin_sync_next;
         pin_level_reg <= pin_level_next;
         filt_cnt_reg <= filt_cnt_next;
         win_latch_reg <= win_latch_next;
         cmp_stat_reg <= cmp_stat_next;
         protect_reg <= protect_next;
         sleep_reg <= sleep_next;
         nvm_ok_reg <= nvm_ok_next;
         lock_reg <= lock_next & ~lock_next_override;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         chan_reg <= chan_next;
         glob_reg <= glob_next;
         reset_hold_reg <= reset_hold_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign pin_o = pin_out_reg;
   assign pin_oe_o = pin_oe_reg;
   assign chan_cmd_o = chan_reg;
   assign glob_cmd_o = glob_reg;
endmodule

/* File: pin_func_checker.sv */
// checker: port-level properties of the pin function block
`timescale 1ns/10ps
module pin_func_checker #(
   parameter int glitch_len = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_ack_o,
   input wire logic pin_i,
   input wire logic [3:0] sync_update_i,
   input wire pin_func_pkg::chan_cmd_t chan_cmd_o,
   input wire pin_func_pkg::glob_cmd_t glob_cmd_o
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_sleep; $changed(glob_cmd_o.sleep) |-> glob_cmd_o.sleep == !pin_i; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep level not tied to pin level");
   property p_clear; $changed(glob_cmd_o.clear) |-> glob_cmd_o.clear == !pin_i; endproperty
   a_clear: assert property (p_clear) else $error("clear level not tied to pin low");
   property p_reset; $changed(glob_cmd_o.dev_reset) |-> glob_cmd_o.dev_reset == !pin_i; endproperty
   a_reset: assert property (p_reset) else $error("device reset not held from fall to rise");
   property p_nvm; $changed(glob_cmd_o.nvm_write_ok) |-> glob_cmd_o.nvm_write_ok == !pin_i; endproperty
   a_nvm: assert property (p_nvm) else $error("memory permit not tied to pin edges");
   property p_lock; $rose(glob_cmd_o.map_locked) |-> pin_i; endproperty
   a_lock: assert property (p_lock) else $error("map locked without a rising pin");
   property p_pulse; chan_cmd_o != '0 |=> (chan_cmd_o == '0) [*3]; endproperty
   a_pulse: assert property (p_pulse) else $error("channel command repeated after one edge");
   property p_load; chan_cmd_o.load != '0 |-> (chan_cmd_o.load & ~sync_update_i) == '0; endproperty
   a_load: assert property (p_load) else $error("load on a channel without sync update");
   property p_fault; glob_cmd_o.fault_snapshot |-> !pin_i ##1 !glob_cmd_o.fault_snapshot; endproperty
   a_fault: assert property (p_fault) else $error("fault snapshot not a pulse on a fall");
   property p_margin; chan_cmd_o.margin_lo != '0 |-> !pin_i; endproperty
   a_margin: assert property (p_margin) else $error("margin low without pin low");
   c_load: cover property (chan_cmd_o.load != '0);
   c_sleep: cover property (glob_cmd_o.sleep);
   c_ack: cover property (wb_ack_o);
endmodule
bind pin_func pin_func_checker #(.glitch_len(glitch_len)) i_pin_func_checker (.clk_i(clk_i), .rst_i(rst_i),
   .wb_ack_o(wb_ack_o), .pin_i(pin_i), .sync_update_i(sync_update_i), .chan_cmd_o(chan_cmd_o),
   .glob_cmd_o(glob_cmd_o));

/* File: pin_ctrl_model.sv */
// partner: external controller that drives or watches the shared pin
`timescale 1ns/10ps
module pin_ctrl_model (
   input wire logic clk_i,
   input wire logic pin_o,
   input wire logic pin_oe_o,
   output logic pin_level_o
);
   logic drive_q = 1'b1;
   // device wins while it drives, else the controller level, idle high
   assign pin_level_o = pin_oe_o ? pin_o : drive_q;
   // one level step held for hold cycles; low then high makes a pulse
   task automatic drive(input logic lvl, input int hold);
      @(posedge clk_i);
      drive_q <= lvl;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule

/* File: tb_pin_func.sv */
// testbench: pin function block against a behavioural model
`timescale 1ns/10ps
module tb_pin_func;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc, wb_stb, wb_we, wb_ack, pin, pin_o, pin_oe, latch_en, mem_busy, prot_act, gf;
   logic [9:0] wb_adr;
   logic [31:0] wb_dat, wb_rd, rdv;
   logic [3:0] cmp_raw, win_raw, sync_upd, busy, code, sel, y;
   logic [15:0] nvm_cfg, c;
   logic [1:0] gseen, ge;
   logic pin_q, nvm_v;
   pin_func_pkg::chan_cmd_t cmd, seen, e;
   pin_func_pkg::glob_cmd_t glob;
   int n_errors = 0, check_count = 0, lat = 0, since = 0, g, ex;
   integer seed = 67;
   int oq[$] = '{1, 4, 5, 6, 7, 8, 9, 10, 11};
   logic [5:0] tq[$] = '{6'h10, 6'h00, 6'h23, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D};
   pin_func i_pin_func (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .pin_i(pin),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .compare_raw_i(cmp_raw), .window_raw_i(win_raw),
      .window_latch_en_i(latch_en), .sync_update_i(sync_upd), .chan_busy_i(busy), .memory_busy_i(mem_busy),
      .protect_active_i(prot_act), .nvm_cfg_valid_i(nvm_v), .nvm_cfg_i(nvm_cfg), .chan_cmd_o(cmd), .glob_cmd_o(glob));
   pin_ctrl_model i_pin_ctrl_model (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_level_o(pin));
   // ************************************************************
   // clock, monitor and shared tasks
   // ************************************************************
   initial forever #2 clk_i = ~clk_i;
   // collects command pulses and their delay after the last pin change
   always @(posedge clk_i) begin
      pin_q <= pin;
      since <= (pin !== pin_q) ? 1 : since + 1;
      if (|cmd || glob.fault_snapshot || glob.protect_start) begin
         seen <= seen | cmd;
         gseen <= gseen | {glob.fault_snapshot, glob.protect_start};
         lat <= since;
      end
   end
   task automatic check(input logic [35:0] got, input logic [35:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [9:0] a, input logic [15:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 100);
      if (n >= 100) begin
         check(1'b0, 1'b1, "ack timeout");
         print_verdict();
      end
      rdv = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic pin_func_pkg::chan_cmd_t exp_cmd(input logic [3:0] f, input logic [3:0] s, input logic [3:0] u);
      pin_func_pkg::chan_cmd_t r;
      r = '0;
      case (f)
         4'h3: {r.current_output_off, r.current_output_on} = {s, s};
         4'h4: {r.voltage_output_off, r.voltage_output_on} = {s, s};
         4'h8: r.load = s & u;
         4'h9: {r.wave_start, r.wave_stop} = {s, s};
         4'hA: {r.margin_lo, r.margin_hi} = {s, s};
         default: r = '0;
      endcase
      return r;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      print_verdict();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, latch_en, mem_busy, prot_act} = '0;
      {cmp_raw, win_raw, sync_upd, busy, seen, gseen, nvm_v} = '0;
      nvm_cfg = $random(seed);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, pin_func_pkg::pin_cfg_addr, 16'h0000);
      check(rdv, 32'h0, "config reset value");
      wb(1'b0, 10'h3FC, 16'h0000);
      check(rdv, 32'h0, "unmapped read");
      $display("test reset values done");
      // output mode: select codes 1 and 4 to 11 drive the pin from their status source
      foreach (oq[i]) begin
         busy <= $random(seed);
         mem_busy <= $random(seed);
         win_raw <= $random(seed);
         wb(1'b1, pin_func_pkg::pin_cfg_addr, {3'b001, oq[i][3:0], 9'h000});
         repeat (6) @(posedge clk_i);
         ex = oq[i] == 1 ? mem_busy : (oq[i] < 8 ? busy[oq[i] - 4] : win_raw[oq[i] - 8]);
         check(pin_oe, 1'b1, "output enable");
         check(pin_o, ex[0], "pin output");
      end
      wb(1'b1, pin_func_pkg::pin_cfg_addr, 16'h0000);
      check(pin_oe, 1'b0, "output disabled");
      $display("test output mode done");
      // status word: live comparators, sticky protect flag, latched window
      cmp_raw <= $random(seed);
      win_raw <= $random(seed);
      prot_act <= 1'b1;
      repeat (6) @(posedge clk_i);
      prot_act <= 1'b0;
      wb(1'b0, pin_func_pkg::comparator_status_addr, 16'h0000);
      check(rdv[8], 1'b1, "protect flag");
      check(rdv[7:0], {win_raw, cmp_raw}, "comparators");
      wb(1'b0, pin_func_pkg::comparator_status_addr, 16'h0000);
      check(rdv[8], 1'b0, "protect flag after read");
      latch_en <= 1'b1;
      win_raw <= 4'hF;
      repeat (6) @(posedge clk_i);
      win_raw <= 4'h0;
      wb(1'b0, pin_func_pkg::comparator_status_addr, 16'h0000);
      check(rdv[7:4], 4'hF, "latched window");
      wb(1'b1, {pin_func_pkg::cmp_clear_addr, 2'b00}, 16'h000F);
      wb(1'b0, pin_func_pkg::comparator_status_addr, 16'h0000);
      check(rdv[7:4], 4'h0, "window after flag clear");
      latch_en <= 1'b0;
      $display("test status word done");
      // input functions: one low pulse per code, random channels and filter
      foreach (tq[i]) begin
         code = tq[i][3:0];
         sel = $random(seed);
         y = $random(seed);
         gf = $random(seed);
         g = gf ? pin_func_pkg::glitch_cycles : 0;
         sync_upd <= y;
         c = {gf, tq[i][4], 1'b0, 4'h0, sel, code, !tq[i][5]};
         nvm_cfg <= c;
         nvm_v <= $random(seed);
         wb(1'b1, pin_func_pkg::pin_cfg_addr, c);
         seen = '0;
         gseen = '0;
         e = tq[i][5] ? '0 : exp_cmd(code, sel, y);
         ge = tq[i][5] ? 2'b00 : {code == 4'h2, code == 4'h5};
         i_pin_ctrl_model.drive(1'b0, 16);
         check(glob, {tq[i][5:4] == 2'b01 && code == 4'h0, 2'b00, code == 4'h7, code == 4'hB, code == 4'hC, 1'b0},
            "levels with pin low");
         i_pin_ctrl_model.drive(1'b1, 16);
         check(seen, e, "channel commands");
         check(gseen, ge, "global pulses");
         check(glob.map_locked, code == 4'hD, "map lock");
         if (|e || |ge) check(lat >= 3 + g && lat <= 6 + g, 1'b1, "edge delay");
         if (code == 4'hB) wb(1'b0, pin_func_pkg::pin_cfg_addr, 16'h0000);
         if (code == 4'hB) check(rdv, nvm_v ? {16'h0000, c} : 32'h0, "config after pin reset");
      end
      $display("test input functions done");
      // locked map refuses a config write until the key is written
      wb(1'b1, pin_func_pkg::pin_cfg_addr, 16'h0001);
      wb(1'b0, pin_func_pkg::pin_cfg_addr, 16'h0000);
      check(rdv[15:0], c, "write while locked");
      wb(1'b1, {pin_func_pkg::map_unlock_addr, 2'b00}, pin_func_pkg::map_unlock_key);
      wb(1'b1, pin_func_pkg::pin_cfg_addr, 16'h0001);
      wb(1'b0, pin_func_pkg::pin_cfg_addr, 16'h0000);
      check(rdv[15:0], 16'h0001, "write after unlock");
      $display("test map lock done");
      print_verdict();
   end
endmodule
